// ==== core/ciee_unit.sv ====
`timescale 1ns/1ps
module ciee_unit #(
    parameter logic [19:0] VEC_BASE = ciee_pkg::VEC_BASE_RESET,
    parameter int NMI_CNT_W = ciee_pkg::NMI_CNT_W_DEFAULT
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Interrupt inputs
    input wire logic nmi_in,
    input wire logic intr_req,
    input wire logic [7:0] intr_type,
    output logic intr_ack,
    // Execution core requests
    input wire logic instr_boundary,
    input wire logic exc_req,
    input wire logic exc_is_fault,
    input wire logic [7:0] exc_type,
    input wire logic swint_req,
    input wire logic [7:0] swint_type,
    input wire logic interrupt_return_instruction_req,
    output logic ready,
    // Execution core state
    input wire logic [15:0] psw_in,
    input wire logic [15:0] cs_in,
    input wire logic [15:0] ip_in,
    input wire logic [15:0] next_ip_in,
    input wire logic [15:0] ss_in,
    input wire logic [15:0] sp_in,
    // Execution core updates
    output logic psw_load,
    output logic [15:0] psw_out,
    output logic cs_ip_load,
    output logic [15:0] cs_out,
    output logic [15:0] ip_out,
    output logic sp_load,
    output logic [15:0] sp_out,
    // Memory port
    output logic mem_req,
    output logic mem_we,
    output logic [19:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata
);

    initial
    begin
        if (VEC_BASE[1:0] != 2'b00 || ciee_pkg::TYPE_COUNT != (1 << ciee_pkg::TYPE_W))
            $error("ciee_unit: vector base must be word-pair aligned");
    end

    // ========================================================
    // Nonmaskable latch
    ciee_nmi_if nmi ();

    ciee_nmi_latch #(.CNT_W(NMI_CNT_W)) u_nmi (
        .core_clk(core_clk),
        .reset(reset),
        .nmi_in(nmi_in),
        .nmi(nmi)
    );

    // ========================================================
    // Sequencer state
    ciee_pkg::ciee_state_e state_q, state_d;
    logic [15:0] sp_q, sp_d, ss_q, ss_d, psw_sv_q, psw_sv_d;
    logic [15:0] cs_sv_q, cs_sv_d, ret_ip_q, ret_ip_d, new_ip_q, new_ip_d;
    logic [19:0] vec_q, vec_d;
    logic [15:0] psw_out_q, psw_out_d, cs_out_q, cs_out_d, ip_out_q, ip_out_d;
    logic psw_load_q, psw_load_d, cs_ip_load_q, cs_ip_load_d, sp_load_q, sp_load_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic we_q, we_d;
    logic acked;
    logic start;
    logic [7:0] start_type;
    logic [15:0] start_ret;

    assign ready = (state_q == ciee_pkg::ST_IDLE);
    assign mem_req = !ready;
    assign acked = mem_req && mem_ack;

    // ========================================================
    // Arbitration at the boundary
    always_comb
    begin
        start = 1'b0;
        start_type = ciee_pkg::NMI_TYPE;
        start_ret = next_ip_in;
        nmi.take = 1'b0;
        intr_ack = 1'b0;
        if (ready && instr_boundary)
        begin
            if (nmi.pending)
            begin
                start = 1'b1;
                nmi.take = 1'b1;
                start_type = ciee_pkg::NMI_TYPE;
            end
            else if (exc_req)
            begin
                start = 1'b1;
                start_type = exc_type;
                start_ret = exc_is_fault ? ip_in : next_ip_in;
            end
            else if (swint_req)
            begin
                start = 1'b1;
                start_type = swint_type;
            end
            else if (intr_req && psw_in[ciee_pkg::PSW_IE_BIT])
            begin
                start = 1'b1;
                intr_ack = 1'b1;
                start_type = intr_type;
            end
        end
    end

    // Bus fields for a state, registered one cycle ahead
    function automatic logic [19:0] bus_addr(input ciee_pkg::ciee_state_e st,
        input logic [15:0] ss, input logic [15:0] sp, input logic [19:0] vec);
        case (st)
            ciee_pkg::ST_PUSH_PSW, ciee_pkg::ST_PUSH_CS, ciee_pkg::ST_PUSH_IP:
                bus_addr = ciee_pkg::phys_addr(ss, sp - ciee_pkg::STACK_STEP);
            ciee_pkg::ST_READ_IP:
                bus_addr = vec;
            ciee_pkg::ST_READ_CS:
                bus_addr = vec + ciee_pkg::VEC_CS_OFFSET;
            ciee_pkg::ST_POP_IP, ciee_pkg::ST_POP_CS, ciee_pkg::ST_POP_PSW:
                bus_addr = ciee_pkg::phys_addr(ss, sp);
            default:
                bus_addr = ciee_pkg::ADDR_RESET;
        endcase
    endfunction : bus_addr

    // ========================================================
    // Next state
    always_comb
    begin
        state_d = state_q;
        sp_d = sp_q;
        ss_d = ss_q;
        psw_sv_d = psw_sv_q;
        cs_sv_d = cs_sv_q;
        ret_ip_d = ret_ip_q;
        new_ip_d = new_ip_q;
        vec_d = vec_q;
        psw_out_d = psw_out_q;
        cs_out_d = cs_out_q;
        ip_out_d = ip_out_q;
        psw_load_d = 1'b0;
        cs_ip_load_d = 1'b0;
        sp_load_d = 1'b0;
        case (state_q)
            ciee_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    state_d = ciee_pkg::ST_PUSH_PSW;
                    psw_sv_d = psw_in;
                    cs_sv_d = cs_in;
                    ret_ip_d = start_ret;
                    sp_d = sp_in;
                    ss_d = ss_in;
                    vec_d = ciee_pkg::vec_addr(VEC_BASE, start_type);
                end
                else if (interrupt_return_instruction_req)
                begin
                    state_d = ciee_pkg::ST_POP_IP;
                    sp_d = sp_in;
                    ss_d = ss_in;
                end
            end
            ciee_pkg::ST_PUSH_PSW:
                if (acked)
                begin
                    sp_d = sp_q - ciee_pkg::STACK_STEP;
                    psw_out_d = psw_sv_q & ciee_pkg::PSW_ENTRY_MASK;
                    psw_load_d = 1'b1;
                    state_d = ciee_pkg::ST_PUSH_CS;
                end
            ciee_pkg::ST_PUSH_CS:
                if (acked)
                begin
                    sp_d = sp_q - ciee_pkg::STACK_STEP;
                    state_d = ciee_pkg::ST_PUSH_IP;
                end
            ciee_pkg::ST_PUSH_IP:
                if (acked)
                begin
                    sp_d = sp_q - ciee_pkg::STACK_STEP;
                    state_d = ciee_pkg::ST_READ_IP;
                end
            ciee_pkg::ST_READ_IP:
                if (acked)
                begin
                    new_ip_d = mem_rdata;
                    state_d = ciee_pkg::ST_READ_CS;
                end
            ciee_pkg::ST_READ_CS:
                if (acked)
                begin
                    cs_out_d = mem_rdata;
                    ip_out_d = new_ip_q;
                    cs_ip_load_d = 1'b1;
                    sp_load_d = 1'b1;
                    state_d = ciee_pkg::ST_IDLE;
                end
            ciee_pkg::ST_POP_IP:
                if (acked)
                begin
                    new_ip_d = mem_rdata;
                    sp_d = sp_q + ciee_pkg::STACK_STEP;
                    state_d = ciee_pkg::ST_POP_CS;
                end
            ciee_pkg::ST_POP_CS:
                if (acked)
                begin
                    cs_out_d = mem_rdata;
                    ip_out_d = new_ip_q;
                    cs_ip_load_d = 1'b1;
                    sp_d = sp_q + ciee_pkg::STACK_STEP;
                    state_d = ciee_pkg::ST_POP_PSW;
                end
            ciee_pkg::ST_POP_PSW:
                if (acked)
                begin
                    psw_out_d = mem_rdata;
                    psw_load_d = 1'b1;
                    sp_d = sp_q + ciee_pkg::STACK_STEP;
                    sp_load_d = 1'b1;
                    state_d = ciee_pkg::ST_IDLE;
                end
            default:
                state_d = ciee_pkg::ST_IDLE;
        endcase
        addr_d = bus_addr(state_d, ss_d, sp_d, vec_d);
        we_d = (state_d == ciee_pkg::ST_PUSH_PSW) || (state_d == ciee_pkg::ST_PUSH_CS)
            || (state_d == ciee_pkg::ST_PUSH_IP);
        case (state_d)
            ciee_pkg::ST_PUSH_PSW: wdata_d = psw_sv_d;
            ciee_pkg::ST_PUSH_CS: wdata_d = cs_sv_d;
            ciee_pkg::ST_PUSH_IP: wdata_d = ret_ip_d;
            default: wdata_d = ciee_pkg::WORD_RESET;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_q <= ciee_pkg::ST_IDLE;
            sp_q <= ciee_pkg::WORD_RESET;
            ss_q <= ciee_pkg::WORD_RESET;
            psw_sv_q <= ciee_pkg::WORD_RESET;
            cs_sv_q <= ciee_pkg::WORD_RESET;
            ret_ip_q <= ciee_pkg::WORD_RESET;
            new_ip_q <= ciee_pkg::WORD_RESET;
            vec_q <= ciee_pkg::ADDR_RESET;
            psw_out_q <= ciee_pkg::WORD_RESET;
            cs_out_q <= ciee_pkg::WORD_RESET;
            ip_out_q <= ciee_pkg::WORD_RESET;
            psw_load_q <= 1'b0;
            cs_ip_load_q <= 1'b0;
            sp_load_q <= 1'b0;
            addr_q <= ciee_pkg::ADDR_RESET;
            wdata_q <= ciee_pkg::WORD_RESET;
            we_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            sp_q <= sp_d;
            ss_q <= ss_d;
            psw_sv_q <= psw_sv_d;
            cs_sv_q <= cs_sv_d;
            ret_ip_q <= ret_ip_d;
            new_ip_q <= new_ip_d;
            vec_q <= vec_d;
            psw_out_q <= psw_out_d;
            cs_out_q <= cs_out_d;
            ip_out_q <= ip_out_d;
            psw_load_q <= psw_load_d;
            cs_ip_load_q <= cs_ip_load_d;
            sp_load_q <= sp_load_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            we_q <= we_d;
        end
    end

    assign psw_load = psw_load_q;
    assign psw_out = psw_out_q;
    assign cs_ip_load = cs_ip_load_q;
    assign cs_out = cs_out_q;
    assign ip_out = ip_out_q;
    assign sp_load = sp_load_q;
    assign sp_out = sp_q;
    assign mem_we = we_q;
    assign mem_addr = addr_q;
    assign mem_wdata = wdata_q;

    // ========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    entry_start_a: assert property (ready && !instr_boundary |=> state_q != ciee_pkg::ST_PUSH_PSW)
        else $error("entry started off a boundary");
    nmi_first_a: assert property (ready && instr_boundary && nmi.pending |-> nmi.take && !intr_ack)
        else $error("nmi not given priority");
    nmi_vector_a: assert property (nmi.take |=> vec_q == VEC_BASE + 20'h00008)
        else $error("nmi vector address wrong");
    mask_gate_a: assert property (intr_ack |-> psw_in[ciee_pkg::PSW_IE_BIT] && !nmi.pending)
        else $error("maskable taken while disabled");
    push_order_a: assert property (state_q == ciee_pkg::ST_PUSH_PSW && acked
        |=> state_q == ciee_pkg::ST_PUSH_CS && psw_load && !psw_out[ciee_pkg::PSW_STEP_BIT]
        && !psw_out[ciee_pkg::PSW_IE_BIT] && mem_wdata == cs_sv_q && mem_we)
        else $error("flags not cleared before segment push");
    push_psw_a: assert property (start |=> state_q == ciee_pkg::ST_PUSH_PSW && mem_we
        && mem_wdata == $past(psw_in)
        && mem_addr == ciee_pkg::phys_addr($past(ss_in), $past(sp_in) - 16'h0002)
        )
        else $error("status word push wrong");
    fault_ret_a: assert property (start && exc_req && exc_is_fault && !nmi.pending
        |=> ret_ip_q == $past(ip_in))
        else $error("fault return address wrong");
    vec_read_a: assert property (state_q == ciee_pkg::ST_PUSH_IP && acked
        |=> mem_addr == vec_q && !mem_we ##0 (state_q == ciee_pkg::ST_READ_IP))
        else $error("vector read address wrong");
    vec_load_a: assert property (state_q == ciee_pkg::ST_READ_CS && acked
        |=> cs_ip_load && cs_out == $past(mem_rdata) && ip_out == new_ip_q && ready)
        else $error("vector not loaded");
    ret_pop_a: assert property (state_q == ciee_pkg::ST_POP_CS && acked
        |=> cs_ip_load && state_q == ciee_pkg::ST_POP_PSW && !psw_load)
        else $error("return address not loaded first");
    psw_pop_a: assert property (state_q == ciee_pkg::ST_POP_PSW && acked
        |=> psw_load && psw_out == $past(mem_rdata) && sp_load && ready)
        else $error("status word not restored");

    nmi_entry_c: cover property (nmi.take ##[1:40] cs_ip_load);
    mask_entry_c: cover property (intr_ack ##[1:40] cs_ip_load);
    interrupt_return_instruction_done_c: cover property (ready && interrupt_return_instruction_req ##[1:40] psw_load && sp_load);
    swint_entry_c: cover property (start && swint_req && !exc_req && !nmi.pending);

endmodule : ciee_unit

// ==== core/ciee_pkg.sv ====
package ciee_pkg;

    // ========================================================
    // Status word layout
    localparam int PSW_STEP_BIT = 8;
    localparam int PSW_IE_BIT = 9;
    localparam logic [15:0] PSW_ENTRY_MASK = 16'hFCFF;

    // ========================================================
    // Vector table
    localparam int TYPE_W = 8;
    localparam int TYPE_COUNT = 256;
    localparam logic [7:0] NMI_TYPE = 8'h02;
    localparam logic [19:0] VEC_CS_OFFSET = 20'h00002;
    localparam logic [19:0] VEC_BASE_RESET = 20'h00000;

    // ========================================================
    // Stack and reset values
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [19:0] ADDR_RESET = 20'h00000;
    localparam int NMI_CNT_W_DEFAULT = 4;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_PUSH_PSW = 4'h1,
        ST_PUSH_CS = 4'h2,
        ST_PUSH_IP = 4'h3,
        ST_READ_IP = 4'h4,
        ST_READ_CS = 4'h5,
        ST_POP_IP = 4'h6,
        ST_POP_CS = 4'h7,
        ST_POP_PSW = 4'h8
    } ciee_state_e;

    // Segment times sixteen plus offset, wrapping at one megabyte
    function automatic logic [19:0] phys_addr(input logic [15:0] seg, input logic [15:0] off);
        phys_addr = {seg, 4'h0} + {4'h0, off};
    endfunction : phys_addr

    // Vector slot: type times four above the table base
    function automatic logic [19:0] vec_addr(input logic [19:0] base, input logic [7:0] ty);
        vec_addr = base + {10'h000, ty, 2'b00};
    endfunction : vec_addr

endpackage : ciee_pkg

// ==== core/ciee_nmi_if.sv ====
`timescale 1ns/1ps
interface ciee_nmi_if;
    logic pending;
    logic take;
    modport latch (output pending, input take);
    modport core (input pending, output take);
endinterface : ciee_nmi_if

// ==== core/ciee_nmi_latch.sv ====
`timescale 1ns/1ps
module ciee_nmi_latch #(
    parameter int CNT_W = ciee_pkg::NMI_CNT_W_DEFAULT
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Pin
    input wire logic nmi_in,
    // Core side
    ciee_nmi_if.latch nmi
);

    // ========================================================
    // Edge detect and request count
    logic prev_q;
    logic prev_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic rise;

    initial
    begin
        if (CNT_W < 1)
            $error("ciee_nmi_latch: CNT_W must be at least 1");
    end

    assign rise = nmi_in & ~prev_q;
    assign nmi.pending = (cnt_q != '0);

    // Count keeps each edge until it saturates at all ones, so back-to-back requests each get an entry
    always_comb
    begin
        prev_d = nmi_in;
        cnt_d = cnt_q;
        if (rise && !nmi.take && !(&cnt_q))
            cnt_d = cnt_q + 1'b1;
        else if (!rise && nmi.take)
            cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            prev_q <= 1'b1;
            cnt_q <= '0;
        end
        else
        begin
            prev_q <= prev_d;
            cnt_q <= cnt_d;
        end
    end

    // ========================================================
    // Checks
    nmi_count_a: assert property (@(posedge core_clk) disable iff (reset)
        rise && !nmi.take && !(&cnt_q) |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("nmi edge not counted");
    nmi_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        nmi.pending && !nmi.take |=> nmi.pending)
        else $error("nmi request lost before service");
    nmi_nest_c: cover property (@(posedge core_clk) disable iff (reset) cnt_q == 2);

endmodule : ciee_nmi_latch

// ==== bench/ciee_mem_model.sv ====
`timescale 1ns/1ps
module ciee_mem_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Word bus
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    // Extra wait cycles per access
    input wire logic [3:0] mem_slow
);
    // ========================================================
    // Storage and access log
    logic [15:0] mem [logic [19:0]];
    logic [19:0] log_q [$];
    logic [3:0] wait_q;
    logic [15:0] last_q;

    always_comb mem_ack = mem_req && (wait_q >= mem_slow);
    // Off-cycle data is the inverse of the last word so stale reads show up
    always_comb mem_rdata = (mem_ack && mem.exists(mem_addr)) ? mem[mem_addr] : ~last_q;

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            wait_q <= 4'h0;
            last_q <= 16'h0000;
        end
        else if (mem_req && mem_ack)
        begin
            wait_q <= 4'h0;
            last_q <= mem_rdata;
            log_q.push_back(mem_addr);
            if (mem_we)
                mem[mem_addr] = mem_wdata;
        end
        else if (mem_req)
            wait_q <= wait_q + 4'h1;
    end
endmodule : ciee_mem_model

// ==== bench/ciee_unit_bench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module ciee_unit_bench;
    localparam logic [19:0] BASE = 20'h00400;
    logic core_clk, reset, nmi_in, intr_req, intr_ack, instr_boundary, exc_req, exc_is_fault;
    logic swint_req, interrupt_return_instruction_req, ready, psw_load, cs_ip_load, sp_load;
    logic mem_req, mem_we, mem_ack;
    logic [7:0] intr_type, exc_type, swint_type;
    logic [15:0] psw_in, cs_in, ip_in, next_ip_in, ss_in, sp_in, psw_out, cs_out, ip_out;
    logic [15:0] sp_out, mem_wdata, mem_rdata;
    logic [19:0] mem_addr;
    logic [3:0] mem_slow;
    int err_total = 0;
    int compares = 0;

    ciee_unit #(.VEC_BASE(BASE), .NMI_CNT_W(4)) ciee_unit_inst (.core_clk, .reset, .nmi_in,
        .intr_req, .intr_type, .intr_ack, .instr_boundary, .exc_req, .exc_is_fault,
        .exc_type, .swint_req, .swint_type, .interrupt_return_instruction_req, .ready, .psw_in, .cs_in, .ip_in,
        .next_ip_in, .ss_in, .sp_in, .psw_load, .psw_out, .cs_ip_load, .cs_out, .ip_out,
        .sp_load, .sp_out, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    ciee_mem_model ciee_mem_model_inst (.core_clk, .reset, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata, .mem_slow);

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ========================================================
    // Shared steps
    task automatic results();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // Caller has set the request lines at this falling edge
    task automatic fire();
        ciee_mem_model_inst.log_q.delete();
        instr_boundary = 1'b1;
        @(negedge core_clk);
        {instr_boundary, exc_req, swint_req, intr_req, interrupt_return_instruction_req} = 5'h00;
    endtask : fire

    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (ready !== 1'b1 && n < 80);
        `CHK(ready, 1'b1)
    endtask : wait_ready

    task automatic check_entry(input logic [7:0] ty, input logic [15:0] ret);
        logic [15:0] p;
        logic [19:0] top;
        logic [19:0] vec;
        p = psw_in;
        p[8] = 1'b0;
        p[9] = 1'b0;
        top = {ss_in, 4'h0} + {4'h0, sp_in};
        vec = BASE + {10'h000, ty, 2'b00};
        wait_ready();
        `CHK(cs_ip_load, 1'b1)
        `CHK(sp_load, 1'b1)
        `CHK(ciee_mem_model_inst.log_q.size(), 5)
        `CHK(ciee_mem_model_inst.log_q[0], top - 20'h00002)
        `CHK(ciee_mem_model_inst.mem[top - 20'h00002], psw_in)
        `CHK(ciee_mem_model_inst.log_q[1], top - 20'h00004)
        `CHK(ciee_mem_model_inst.mem[top - 20'h00004], cs_in)
        `CHK(ciee_mem_model_inst.log_q[2], top - 20'h00006)
        `CHK(ciee_mem_model_inst.mem[top - 20'h00006], ret)
        `CHK(ciee_mem_model_inst.log_q[3], vec)
        `CHK(ciee_mem_model_inst.log_q[4], vec + 20'h00002)
        `CHK(psw_out, p)
        `CHK(cs_out, {8'h5A, ty})
        `CHK(ip_out, {8'hA5, ty})
        `CHK(sp_out, sp_in - 16'h0006)
    endtask : check_entry

    // ========================================================
    // Scenarios
    task automatic t_swint_all();
        for (int t = 0; t < 256; t++)
        begin
            mem_slow = (t == 7) ? 4'h3 : 4'h0;
            swint_req = 1'b1;
            swint_type = t[7:0];
            fire();
            check_entry(t[7:0], next_ip_in);
        end
    endtask : t_swint_all

    task automatic t_exc();
        for (int f = 0; f < 2; f++)
        begin
            exc_req = 1'b1;
            exc_is_fault = f[0];
            exc_type = 8'h10;
            fire();
            check_entry(8'h10, f[0] ? ip_in : next_ip_in);
        end
    endtask : t_exc

    task automatic t_nmi();
        // Two separate edges, each held two clocks, with no boundary yet
        repeat (2)
        begin
            nmi_in = 1'b1;
            repeat (2) @(negedge core_clk);
            nmi_in = 1'b0;
            repeat (2) @(negedge core_clk);
        end
        repeat (4) @(negedge core_clk);
        `CHK(ready, 1'b1)
        `CHK(mem_req, 1'b0)
        psw_in = 16'h0000;
        exc_req = 1'b1;
        exc_is_fault = 1'b0;
        exc_type = 8'h05;
        fire();
        check_entry(8'h02, next_ip_in);
        fire();
        check_entry(8'h02, next_ip_in);
        fire();
        `CHK(ready, 1'b1)
        psw_in = 16'hFFFF;
    endtask : t_nmi

    task automatic t_mask();
        for (int ie = 0; ie < 2; ie++)
        begin
            psw_in[9] = ie[0];
            intr_req = 1'b1;
            intr_type = 8'h47;
            instr_boundary = 1'b1;
            #1;
            `CHK(intr_ack, ie[0])
            fire();
            if (ie == 0)
                `CHK(ready, 1'b1)
            else
                check_entry(8'h47, next_ip_in);
        end
    endtask : t_mask

    task automatic t_interrupt_return_instruction();
        logic [19:0] top;
        top = {ss_in, 4'h0} + {4'h0, sp_in};
        ciee_mem_model_inst.mem[top] = 16'h3C21;
        ciee_mem_model_inst.mem[top + 20'h00002] = 16'h4D32;
        ciee_mem_model_inst.mem[top + 20'h00004] = 16'h0B43;
        interrupt_return_instruction_req = 1'b1;
        fire();
        wait_ready();
        `CHK(psw_load, 1'b1)
        `CHK(sp_load, 1'b1)
        `CHK(cs_ip_load, 1'b0)
        `CHK(ciee_mem_model_inst.log_q[0], top)
        `CHK(ciee_mem_model_inst.log_q[1], top + 20'h00002)
        `CHK(ciee_mem_model_inst.log_q[2], top + 20'h00004)
        `CHK(ip_out, 16'h3C21)
        `CHK(cs_out, 16'h4D32)
        `CHK(psw_out, 16'h0B43)
        `CHK(sp_out, sp_in + 16'h0006)
    endtask : t_interrupt_return_instruction

    // ========================================================
    // Main sequence and watchdog
    initial
    begin
        {reset, nmi_in, intr_req, instr_boundary, exc_req, exc_is_fault} = 6'h20;
        {swint_req, interrupt_return_instruction_req} = 2'b00;
        {intr_type, exc_type, swint_type} = 24'h000000;
        {psw_in, cs_in, ip_in, next_ip_in} = 64'hFFFF_6E00_0120_0124;
        {ss_in, sp_in} = 32'h1000_0100;
        mem_slow = 4'h0;
        // Vector table: pointer in low word, segment above it
        for (int t = 0; t < 256; t++)
        begin
            ciee_mem_model_inst.mem[BASE + 20'(t * 4)] = {8'hA5, t[7:0]};
            ciee_mem_model_inst.mem[BASE + 20'(t * 4 + 2)] = {8'h5A, t[7:0]};
        end
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        t_swint_all();
        t_exc();
        t_nmi();
        t_mask();
        t_interrupt_return_instruction();
        results();
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        results();
    end
endmodule : ciee_unit_bench
